// ==== src/dcw_decoder.v ====
// Purpose: hold and decode the drive command word from the network
// Assumes: network and local ports are same-clock logic; settings are pins
// Notes:   commands act only when the profile and source allow them
// Notes on behaviour
// - writes to read-only words change nothing
// - unused register locations read as zero
// - 16-bit command word, resets to zero
// - only the network port may write
// - decode only with standard profile selected
// - execute only when network commands drive
// - bit 0 clear stops and disables drive
// - bit 1 clear disables by coasting
// - bit 2 clear fast stops then disables
// - bit 3 enables or disables the drive
// - bit 4 clear ramps down; set enables ramp
// - bit 6 clear zeroes speed reference
// - bit 7 rising edge resets fault when faulted
// - bit 8 enables the jog function
// - bit 10 selects local or remote
// - real sources come from source settings
`timescale 1ns/1ns
`include "dcw_consts.vh"
module dcw_decoder #(
  parameter WORD_W = `DCW_WORD_W,
  parameter ADDR_W = `DCW_ADDR_W
) (
  input  wire              sys_clk_i,
  input  wire              rst_b_i,
  input  wire              ce_i,
  // network port (same clock)
  input  wire              net_wr_i,
  input  wire              net_rd_i,
  input  wire [ADDR_W-1:0] net_addr_i,
  input  wire [WORD_W-1:0] net_wdata_i,
  output reg  [WORD_W-1:0] net_rdata_o,
  output wire              net_ack_o,
  // other sources such as panel or second bus (same clock)
  input  wire              loc_wr_i,
  input  wire              loc_rd_i,
  input  wire [ADDR_W-1:0] loc_addr_i,
  input  wire [WORD_W-1:0] loc_wdata_i,
  output reg  [WORD_W-1:0] loc_rdata_o,
  output wire              loc_ack_o,
  // drive settings and state (pins)
  input  wire [1:0]        data_profile_select_i,
  input  wire [1:0]        local_remote_source_select_i,
  input  wire [1:0]        jog_source_select_i,
  input  wire [1:0]        ramp_set_select_i,
  input  wire [1:0]        motor_control_type_select_i,
  input  wire              drive_fault_i,
  // decoded drive commands
  output reg               run_permit_o,
  output reg               off_stop_o,
  output reg               coast_stop_o,
  output reg               quick_stop_o,
  output reg               drive_enable_o,
  output reg               ramp_enable_o,
  output reg               ramp_down_o,
  output reg               setpoint_enable_o,
  output reg  [WORD_W-1:0] speed_ref_o,
  output reg               reverse_o,
  output reg               fault_reset_o,
  output reg               jog_request_o,
  output reg               remote_request_o,
  output reg               local_net_cmd_o,
  output reg               remote_net_cmd_o,
  output reg               jog_net_cmd_o,
  output reg               qstop_advised_off_o,
  output reg               cmd_active_o
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronise the drive settings and fault pin
  localparam SYN_W = 11;
  wire [SYN_W-1:0] syn_w;
  dcw_sync2 #(
    .W (SYN_W)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    .d_i       ({drive_fault_i, motor_control_type_select_i, ramp_set_select_i,
                 jog_source_select_i, local_remote_source_select_i, data_profile_select_i}),
    .q_o       (syn_w)
  );
  wire [1:0] profile_w = syn_w[1:0];
  wire [1:0] lr_src_w  = syn_w[3:2];
  wire [1:0] jog_src_w = syn_w[5:4];
  wire [1:0] ramp_src_w = syn_w[7:6];
  wire [1:0] ctrl_w    = syn_w[9:8];
  wire       fault_w   = syn_w[10];

  ////////////////////////////////////////////////////////////////////////////
  // command word and speed reference storage
  reg [WORD_W-1:0] cmd_q;
  reg [WORD_W-1:0] speed_q;
  wire net_cmd_wr_w = ce_i & net_wr_i & (net_addr_i == `DCW_ADDR_CMD);
  wire net_spd_wr_w = ce_i & net_wr_i & (net_addr_i == `DCW_ADDR_SPEED);

  // local writes never reach storage
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cmd_q   <= `DCW_WORD_RESET;
      speed_q <= {WORD_W{1'b0}};
    end
    else
    begin
      if (net_cmd_wr_w)
        cmd_q <= net_wdata_i;
      if (net_spd_wr_w)
        speed_q <= net_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gating by profile and command source
  wire profile_ok_w = (profile_w == `DCW_PROFILE_STD);
  wire lr_net_w     = (lr_src_w == `DCW_SRC_NET);
  wire jog_net_w    = (jog_src_w == `DCW_SRC_NET);
  wire ramp_net_w   = (ramp_src_w == `DCW_SRC_NET);
  wire exec_w       = profile_ok_w & (lr_net_w | jog_net_w | ramp_net_w);
  wire [WORD_W-1:0] eff_w = exec_w ? (cmd_q & `DCW_USED_MASK) : {WORD_W{1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  // fault acknowledge edge
  wire ack_rise_w;
  dcw_rise u_rise (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    .lvl_i     (eff_w[`DCW_BIT_FAULT_ACK]),
    .pulse_o   (ack_rise_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status word for reads: bit0 active, bit1 profile ok, bit2 fault
  wire [WORD_W-1:0] stat_w = {{(WORD_W-3){1'b0}}, fault_w, profile_ok_w, exec_w};

  // shared read mux
  function [WORD_W-1:0] rd_mux;
    input [ADDR_W-1:0] a;
    begin
      case (a)
        `DCW_ADDR_CMD:   rd_mux = cmd_q;
        `DCW_ADDR_SPEED: rd_mux = speed_q;
        `DCW_ADDR_STAT:  rd_mux = stat_w;
        default:         rd_mux = {WORD_W{1'b0}};
      endcase
    end
  endfunction

  // registered read data, one cycle after strobe
  reg net_ack_q;
  reg loc_ack_q;
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      net_rdata_o <= {WORD_W{1'b0}};
      loc_rdata_o <= {WORD_W{1'b0}};
      net_ack_q   <= 1'b0;
      loc_ack_q   <= 1'b0;
    end
    else if (ce_i)
    begin
      net_ack_q <= net_rd_i | net_wr_i;
      loc_ack_q <= loc_rd_i | loc_wr_i;
      if (net_rd_i)
        net_rdata_o <= rd_mux(net_addr_i);
      if (loc_rd_i)
        loc_rdata_o <= rd_mux(loc_addr_i);
    end
  end
  assign net_ack_o = net_ack_q;
  assign loc_ack_o = loc_ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // decoded drive commands, registered
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      run_permit_o        <= 1'b0;
      off_stop_o          <= 1'b0;
      coast_stop_o        <= 1'b0;
      quick_stop_o        <= 1'b0;
      drive_enable_o      <= 1'b0;
      ramp_enable_o       <= 1'b0;
      ramp_down_o         <= 1'b0;
      setpoint_enable_o   <= 1'b0;
      speed_ref_o         <= {WORD_W{1'b0}};
      reverse_o           <= 1'b0;
      fault_reset_o       <= 1'b0;
      jog_request_o       <= 1'b0;
      remote_request_o    <= 1'b0;
      local_net_cmd_o     <= 1'b0;
      remote_net_cmd_o    <= 1'b0;
      jog_net_cmd_o       <= 1'b0;
      qstop_advised_off_o <= 1'b0;
      cmd_active_o        <= 1'b0;
    end
    else if (ce_i)
    begin
      cmd_active_o      <= exec_w;
      run_permit_o      <= eff_w[`DCW_BIT_ON];
      off_stop_o        <= exec_w & ~eff_w[`DCW_BIT_ON];
      coast_stop_o      <= exec_w & ~eff_w[`DCW_BIT_NO_COAST];
      quick_stop_o      <= exec_w & ~eff_w[`DCW_BIT_NO_QSTOP];
      // enable needs every permissive bit
      drive_enable_o    <= eff_w[`DCW_BIT_EN_OP] & eff_w[`DCW_BIT_ON] &
                           eff_w[`DCW_BIT_NO_COAST] & eff_w[`DCW_BIT_NO_QSTOP];
      ramp_enable_o     <= eff_w[`DCW_BIT_EN_RAMP];
      ramp_down_o       <= exec_w & ~eff_w[`DCW_BIT_EN_RAMP];
      setpoint_enable_o <= eff_w[`DCW_BIT_EN_SETPT];
      speed_ref_o       <= eff_w[`DCW_BIT_EN_SETPT] ? speed_q : {WORD_W{1'b0}};
      reverse_o         <= eff_w[`DCW_BIT_EN_SETPT] & speed_q[WORD_W-1];
      fault_reset_o     <= ack_rise_w & fault_w;
      jog_request_o     <= eff_w[`DCW_BIT_JOG];
      remote_request_o  <= eff_w[`DCW_BIT_REMOTE];
      // which sources actually obey the network follows the settings
      local_net_cmd_o   <= exec_w & ~eff_w[`DCW_BIT_REMOTE] & lr_net_w;
      remote_net_cmd_o  <= exec_w & eff_w[`DCW_BIT_REMOTE] & lr_net_w;
      jog_net_cmd_o     <= exec_w & jog_net_w;
      qstop_advised_off_o <= (ctrl_w == `DCW_CTRL_VF) | (ctrl_w == `DCW_CTRL_VVW);
    end
  end

endmodule // dcw_decoder

// ==== src/dcw_consts.vh ====
// Purpose: constants for the drive control word decoder
// Assumes: 16-bit control word, one clock domain
// Notes:   definitions only
`ifndef DCW_CONSTS_VH
`define DCW_CONSTS_VH
`define DCW_WORD_W        16
`define DCW_WORD_RESET    16'h0000
`define DCW_ADDR_W        8
`define DCW_ADDR_CMD      8'h00
`define DCW_ADDR_SPEED    8'h01
`define DCW_ADDR_STAT     8'h02
`define DCW_BIT_ON        0
`define DCW_BIT_NO_COAST  1
`define DCW_BIT_NO_QSTOP  2
`define DCW_BIT_EN_OP     3
`define DCW_BIT_EN_RAMP   4
`define DCW_BIT_EN_SETPT  6
`define DCW_BIT_FAULT_ACK 7
`define DCW_BIT_JOG       8
`define DCW_BIT_REMOTE    10
`define DCW_USED_MASK     16'h05DF
`define DCW_PROFILE_W     2
`define DCW_PROFILE_STD   2'h1
`define DCW_SRC_W         2
`define DCW_SRC_NET       2'h2
`define DCW_CTRL_W        2
`define DCW_CTRL_VF       2'h0
`define DCW_CTRL_VVW      2'h1
`endif

// ==== src/dcw_sync2.v ====
// Purpose: two-flop synchroniser for pin inputs
// Assumes: asynchronous active-low reset
// Notes:   first flop feeds only the second
`timescale 1ns/1ns
module dcw_sync2 #(
  parameter W = 1
) (
  input  wire         sys_clk_i,
  input  wire         rst_b_i,
  input  wire         ce_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  // two-stage capture
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end
    else if (ce_i)
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule // dcw_sync2

// ==== src/dcw_rise.v ====
// Purpose: rising-edge pulse detector
// Assumes: input already synchronous
// Notes:   one pulse per low-to-high change
`timescale 1ns/1ns
module dcw_rise (
  input  wire sys_clk_i,
  input  wire rst_b_i,
  input  wire ce_i,
  input  wire lvl_i,
  output wire pulse_o
);
  reg prev_q;
  // remember last level
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      prev_q <= 1'b0;
    else if (ce_i)
      prev_q <= lvl_i;
  end
  assign pulse_o = ce_i & lvl_i & ~prev_q;
endmodule // dcw_rise

// ==== verif/dcw_decoder_asserts.sv ====
// Purpose: port checks for the drive command word decoder
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every decoder instance
`timescale 1ns/1ns
module dcw_decoder_asserts #(
  parameter WORD_W = 16
) (
  input wire logic              sys_clk_i, rst_b_i, ce_i, net_wr_i, net_rd_i, loc_wr_i, loc_rd_i,
  input wire logic              net_ack_o, loc_ack_o, run_permit_o, off_stop_o, coast_stop_o, quick_stop_o,
  input wire logic              drive_enable_o, ramp_enable_o, ramp_down_o, setpoint_enable_o, reverse_o,
  input wire logic              fault_reset_o, remote_request_o, local_net_cmd_o, remote_net_cmd_o,
  input wire logic              jog_request_o, cmd_active_o,
  input wire logic [WORD_W-1:0] speed_ref_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // requests taken on either port
  wire net_req = ce_i && (net_wr_i || net_rd_i);
  wire loc_req = ce_i && (loc_wr_i || loc_rd_i);
  sequence s_net_take; net_req; endsequence
  sequence s_net_answer; net_ack_o; endsequence
  net_ack_a: assert property (s_net_take |=> s_net_answer) else $error("network request not answered");
  ack_cause_a: assert property (net_ack_o |-> $past(net_req)) else $error("answer without request");
  loc_ack_a: assert property (loc_req |=> loc_ack_o) else $error("local request not answered");
  idle_zero_a: assert property (!cmd_active_o |-> !(run_permit_o || off_stop_o || coast_stop_o || quick_stop_o
    || drive_enable_o || ramp_down_o || jog_request_o || remote_request_o)) else $error("command while inactive");
  off_on_a: assert property (cmd_active_o |-> run_permit_o != off_stop_o) else $error("on/off pair wrong");
  enable_gate_a: assert property (drive_enable_o |-> run_permit_o && !coast_stop_o && !quick_stop_o)
    else $error("enable while stopped");
  ramp_pair_a: assert property (cmd_active_o |-> ramp_enable_o != ramp_down_o) else $error("ramp pair wrong");
  setpt_zero_a: assert property (!setpoint_enable_o |-> speed_ref_o == '0 && !reverse_o)
    else $error("speed not zeroed");
  reverse_sign_a: assert property (reverse_o == speed_ref_o[WORD_W-1]) else $error("reverse not sign");
  reset_pulse_a: assert property (fault_reset_o |=> !fault_reset_o) else $error("fault reset repeated");
  side_pick_a: assert property (remote_net_cmd_o |-> remote_request_o && !local_net_cmd_o)
    else $error("local/remote mixed");
endmodule // dcw_decoder_asserts
bind dcw_decoder dcw_decoder_asserts #(.WORD_W(WORD_W)) i_dcw_decoder_asserts (.sys_clk_i, .rst_b_i, .ce_i,
  .net_wr_i, .net_rd_i, .loc_wr_i, .loc_rd_i, .net_ack_o, .loc_ack_o, .run_permit_o, .off_stop_o, .coast_stop_o,
  .quick_stop_o, .drive_enable_o, .ramp_enable_o, .ramp_down_o, .setpoint_enable_o, .reverse_o, .fault_reset_o,
  .remote_request_o, .local_net_cmd_o, .remote_net_cmd_o, .jog_request_o, .cmd_active_o, .speed_ref_o);

// ==== verif/dcw_bus_master.sv ====
// Purpose: master model for one register port of the decoder
// Assumes: one-cycle strobes, answer one cycle after the take edge
// Notes:   released address and data lines show inverted values
`timescale 1ns/1ns
module dcw_bus_master (
  input  wire logic        clk_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic [7:0]       addr_o,
  output logic [15:0]      wdata_o,
  input  wire logic [15:0] rdata_i,
  input  wire logic        ack_i
);
  // lines idle low at time zero
  initial {wr_o, rd_o, addr_o, wdata_o} = '0;
  // one transfer: strobe for one cycle, then wait a bounded time for the answer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    int n = 0;
    @(posedge clk_i);
    wr_o <= w;
    rd_o <= !w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    do @(posedge clk_i); while (ack_i !== 1'b1 && ++n < 8);
    q = rdata_i;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
endmodule // dcw_bus_master

// ==== verif/drive_control_word_decoder_tb_top.sv ====
// Purpose: self-checking bench for the drive command word decoder
// Assumes: settings pins need three edges, command outputs two after a write
// Notes:   expected outputs come from the bit meanings below
`timescale 1ns/1ns
`include "dcw_consts.vh"
`define chk(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module drive_control_word_decoder_tb_top;
  logic        clk = 1'b0, rst_b = 1'b0, fault = 1'b0;
  logic [1:0]  prof = 2'h0, lrs = 2'h0, jogs = 2'h0, ctype = 2'h0;
  logic [15:0] q;
  wire         nwr, nrd, lwr, lrd, nack, lack, rev, frst, jnet, qadv, act;
  wire  [7:0]  naddr, laddr;
  wire  [15:0] nwd, lwd, nrdat, lrdat, spd;
  wire  [11:0] outs;
  int          n_mismatch = 0, check_count = 0, n_fr = 0;
  logic [15:0] words [12] = '{16'hFFFF, 16'hFFFE, 16'hFFFD, 16'hFFFB, 16'hFFF7, 16'hFFEF, 16'hFFBF, 16'hFEFF,
                              16'hFBFF, 16'hFA20, 16'h05DF, 16'h0000};
  dcw_decoder i_dcw_decoder (.sys_clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1), .net_wr_i(nwr), .net_rd_i(nrd),
    .net_addr_i(naddr), .net_wdata_i(nwd), .net_rdata_o(nrdat), .net_ack_o(nack), .loc_wr_i(lwr), .loc_rd_i(lrd),
    .loc_addr_i(laddr), .loc_wdata_i(lwd), .loc_rdata_o(lrdat), .loc_ack_o(lack), .data_profile_select_i(prof),
    .local_remote_source_select_i(lrs), .jog_source_select_i(jogs), .ramp_set_select_i(2'h0),
    .motor_control_type_select_i(ctype), .drive_fault_i(fault), .run_permit_o(outs[11]), .off_stop_o(outs[10]),
    .coast_stop_o(outs[9]), .quick_stop_o(outs[8]), .drive_enable_o(outs[7]), .ramp_enable_o(outs[6]),
    .ramp_down_o(outs[5]), .setpoint_enable_o(outs[4]), .speed_ref_o(spd), .reverse_o(rev), .fault_reset_o(frst),
    .jog_request_o(outs[3]), .remote_request_o(outs[2]), .local_net_cmd_o(outs[1]), .remote_net_cmd_o(outs[0]),
    .jog_net_cmd_o(jnet), .qstop_advised_off_o(qadv), .cmd_active_o(act));
  dcw_bus_master i_net (.clk_i(clk), .wr_o(nwr), .rd_o(nrd), .addr_o(naddr), .wdata_o(nwd), .rdata_i(nrdat),
    .ack_i(nack));
  dcw_bus_master i_loc (.clk_i(clk), .wr_o(lwr), .rd_o(lrd), .addr_o(laddr), .wdata_o(lwd), .rdata_i(lrdat),
    .ack_i(lack));
  // expected outputs for a word, network source on the local/remote setting
  function automatic logic [11:0] exp_out(input logic [15:0] w, input logic ex);
    logic [15:0] m;
    m = ex ? w : 16'h0000;
    return {m[0], ex & ~m[0], ex & ~m[1], ex & ~m[2], &m[3:0], m[4], ex & ~m[4], m[6], m[8], m[10], ex & ~m[10],
            ex & m[10]};
  endfunction
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // clock, fault reset pulse counter and watchdog
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (frst === 1'b1) n_fr++;
  initial
  begin
    #20000;
    n_mismatch++;
    end_of_test;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    i_net.xfer(1'b0, `DCW_ADDR_CMD, 16'h0000, q);
    `chk("reset word", 16'h0000, q)
    i_net.xfer(1'b1, 8'h3C, 16'h1234, q);
    i_net.xfer(1'b0, 8'h3C, 16'h0000, q);
    `chk("unused read", 16'h0000, q)
    `chk("idle outputs", 12'h000, outs)
    prof <= `DCW_PROFILE_STD;
    lrs <= `DCW_SRC_NET;
    ctype <= 2'h3;
    i_net.xfer(1'b1, `DCW_ADDR_CMD, 16'hFFFF, q);
    i_loc.xfer(1'b1, `DCW_ADDR_CMD, 16'h0000, q);
    i_loc.xfer(1'b0, `DCW_ADDR_CMD, 16'h0000, q);
    `chk("local read", 16'hFFFF, q)
    i_net.xfer(1'b1, `DCW_ADDR_SPEED, 16'h8005, q);
    settle;
    `chk("speed", {16'h8005, 1'b1}, {spd, rev})
    foreach (words[i])
    begin
      i_net.xfer(1'b1, `DCW_ADDR_CMD, words[i], q);
      settle;
      `chk("commands", exp_out(words[i], 1'b1), outs)
    end
    `chk("speed zeroed", 17'h0, {spd, rev})
    i_net.xfer(1'b1, `DCW_ADDR_CMD, 16'h0080, q);
    settle;
    `chk("no fault", 0, n_fr)
    i_net.xfer(1'b1, `DCW_ADDR_CMD, 16'h0000, q);
    fault <= 1'b1;
    settle;
    i_net.xfer(1'b1, `DCW_ADDR_CMD, 16'h0080, q);
    i_net.xfer(1'b1, `DCW_ADDR_CMD, 16'h0180, q);
    settle;
    `chk("fault resets", 1, n_fr)
    prof <= 2'h0;
    settle;
    `chk("profile off", 13'h0, {outs, act})
    prof <= `DCW_PROFILE_STD;
    lrs <= 2'h0;
    settle;
    `chk("source off", 13'h0, {outs, act})
    jogs <= `DCW_SRC_NET;
    settle;
    `chk("jog source", 3'h7, {jnet, act, outs[3]})
    for (int c = 0; c < 4; c++)
    begin
      ctype <= c[1:0];
      settle;
      `chk("qstop advice", c < 2, qadv)
    end
    end_of_test;
  end
endmodule // drive_control_word_decoder_tb_top
